// [rtl/csc_counter.sv]
// Top of the cycle stamp counter: count, read instruction, model register and identify.
// Notes on behaviour
// - 64-bit count, zero after processor reset.
// - Keeps counting during halt or stop clock.
// - May pause while deep sleep pin asserted.
// - Core variant: one per core clock cycle.
// - Constant variant: fixed rate, ignores frequency changes.
// - Each read returns a strictly greater value.
// - Width and rate avoid wrap for ten years.
// - Restrict flag limits reads to level zero.
// - Read need not serialize with other instructions.
// - Model register 10h reads and writes count.
// - Older write: low half loaded, high cleared.
// - Newer write: all 64 bits loaded.
// - Identify leaf 1 reports counter in bit 4.
`default_nettype none
module csc_counter (
	input  wire logic                            ref_clk,
	input  wire logic                            srst,
	input  wire logic                            core_tick,
	input  wire logic                            const_tick,
	input  wire logic                            const_rate_mode,
	input  wire logic                            full_width_write,
	input  wire logic                            halt_instruction_active,
	input  wire logic                            stop_clock_pin_n,
	input  wire logic                            deep_sleep_pin_n,
	input  wire logic                            sleep_stop_en,
	input  wire logic                            rd_req,
	input  wire logic [csc_pkg::CSC_CPL_W-1:0]   rd_cpl,
	input  wire logic                            rd_v86,
	output logic                                 rd_ack,
	output logic                                 rd_fault,
	output logic [csc_pkg::CSC_CNT_W-1:0]        rd_data,
	input  wire logic                            ctl4_wr,
	input  wire logic [csc_pkg::CSC_CTL4_W-1:0]  ctl4_wdata,
	output logic [csc_pkg::CSC_CTL4_W-1:0]       ctl4_q,
	input  wire logic                            msr_rd,
	input  wire logic                            msr_wr,
	input  wire logic [csc_pkg::CSC_ADDR_W-1:0]  msr_addr,
	input  wire logic [csc_pkg::CSC_CNT_W-1:0]   msr_wdata,
	output logic                                 msr_ack,
	output logic                                 msr_fault,
	output logic [csc_pkg::CSC_CNT_W-1:0]        msr_rdata,
	input  wire logic                            id_req,
	input  wire logic [csc_pkg::CSC_ADDR_W-1:0]  id_leaf,
	output logic                                 id_ack,
	output logic [csc_pkg::CSC_HALF_W-1:0]       id_edx
);
	import csc_pkg::*;

	logic [CSC_CNT_W-1:0]  count_ff;
	logic [CSC_CNT_W-1:0]  nxt_count;
	logic [CSC_CTL4_W-1:0] ctl4_ff;
	logic                  tick;
	logic                  allow;
	logic                  hit;
	logic                  stamp_wr;
	logic                  rd_take;
	logic                  bump;
	logic                  rd_ack_ff;
	logic                  rd_fault_ff;
	logic [CSC_CNT_W-1:0]  rd_data_ff;
	logic                  msr_ack_ff;
	logic                  msr_fault_ff;
	logic [CSC_CNT_W-1:0]  msr_rdata_ff;
	logic                  id_ack_ff;
	logic [CSC_HALF_W-1:0] id_edx_ff;

	// Increment source selection with the optional deep sleep pause.
	csc_tick_sel i_csc_tick_sel (
		.core_tick        (core_tick),
		.const_tick       (const_tick),
		.const_rate_mode  (const_rate_mode),
		.deep_sleep_pin_n (deep_sleep_pin_n),
		.sleep_stop_en    (sleep_stop_en),
		.tick             (tick)
	);

	// Privilege check of the counter read instruction.
	csc_read_guard i_csc_read_guard (
		.restrict_flag (ctl4_ff[CSC_RESTRICT_BIT]),
		.cpl           (rd_cpl),
		.v86_mode      (rd_v86),
		.allow         (allow)
	);

	// Address decode and the qualified events of this cycle.
	assign hit      = (msr_addr == CSC_STAMP_ADDR);
	assign stamp_wr = msr_wr & hit;
	assign rd_take  = rd_req & allow;
	// A read with no tick in its cycle pushes the count on so the next read differs.
	assign bump     = tick | rd_take;

	// Next count: a register write wins over any increment in the same cycle.
	always_comb begin
		nxt_count = count_ff;
		if (stamp_wr) begin
			if (full_width_write) begin
				nxt_count = msr_wdata;
			end else begin
				nxt_count = {{CSC_HALF_W{1'b0}}, msr_wdata[CSC_HALF_W-1:0]};
			end
		end else if (bump) begin
			nxt_count = count_ff + 64'h1;
		end
	end

	// The count itself, cleared by reset and advanced on every selected tick or allowed read unless a write loads it.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_ff <= CSC_STAMP_RESET;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Control register four, which carries the read restriction flag.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctl4_ff <= CSC_CTL4_RESET;
		end else if (ctl4_wr) begin
			ctl4_ff <= ctl4_wdata;
		end
	end

	// Read instruction answer; the sample is the count at the request edge, unordered.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_ack_ff   <= 1'b0;
			rd_fault_ff <= 1'b0;
			rd_data_ff  <= CSC_STAMP_RESET;
		end else begin
			rd_ack_ff   <= rd_req;
			rd_fault_ff <= rd_req & ~allow;
			if (rd_take) begin
				rd_data_ff <= count_ff;
			end
		end
	end

	// Model register answer; other addresses are refused with a fault.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			msr_ack_ff   <= 1'b0;
			msr_fault_ff <= 1'b0;
			msr_rdata_ff <= CSC_STAMP_RESET;
		end else begin
			msr_ack_ff   <= msr_rd | msr_wr;
			msr_fault_ff <= (msr_rd | msr_wr) & ~hit;
			if (msr_rd & hit) begin
				msr_rdata_ff <= count_ff;
			end else if (msr_rd) begin
				msr_rdata_ff <= CSC_STAMP_RESET;
			end
		end
	end

	// Identification query; only the feature leaf reports the counter.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			id_ack_ff <= 1'b0;
			id_edx_ff <= 32'h0;
		end else begin
			id_ack_ff <= id_req;
			if (id_req) begin
				id_edx_ff <= (id_leaf == CSC_ID_FEATURE_LEAF) ? CSC_ID_FEATURES : 32'h0;
			end
		end
	end

	// Outputs come straight from flip-flops.
	assign rd_ack    = rd_ack_ff;
	assign rd_fault  = rd_fault_ff;
	assign rd_data   = rd_data_ff;
	assign ctl4_q    = ctl4_ff;
	assign msr_ack   = msr_ack_ff;
	assign msr_fault = msr_fault_ff;
	assign msr_rdata = msr_rdata_ff;
	assign id_ack    = id_ack_ff;
	assign id_edx    = id_edx_ff;

	// Helper state for the ordering check: last allowed read sample and whether one exists.
	// A write or a wrap after that sample excuses the next sample from growing.
	logic                 seen_ff;
	logic                 wrote_ff;
	logic                 wrap;
	logic [CSC_CNT_W-1:0] last_rd_ff;
	assign wrap = bump & ~stamp_wr & (count_ff == {CSC_CNT_W{1'b1}});
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			seen_ff    <= 1'b0;
			wrote_ff   <= 1'b0;
			last_rd_ff <= CSC_STAMP_RESET;
		end else if (rd_take) begin
			seen_ff    <= 1'b1;
			wrote_ff   <= stamp_wr | wrap;
			last_rd_ff <= count_ff;
		end else if (stamp_wr | wrap) begin
			wrote_ff   <= 1'b1;
		end
	end

	// Reset clears the count and holds it while applied.
	a_reset_clears: assert property (@(posedge ref_clk)
		srst |=> (count_ff == 64'h0))
		else $error("count not zero after reset");

	// Halt and stop clock do not stop counting.
	a_halt_counts: assert property (@(posedge ref_clk) disable iff (srst)
		(halt_instruction_active | ~stop_clock_pin_n) & tick & ~stamp_wr
		|=> count_ff == $past(count_ff) + 64'h1)
		else $error("count stalled during halt or stop clock");

	// Deep sleep with the pause enabled freezes the count.
	a_sleep_holds: assert property (@(posedge ref_clk) disable iff (srst)
		(~deep_sleep_pin_n & sleep_stop_en & ~stamp_wr & ~rd_req) [*2]
		|=> $stable(count_ff))
		else $error("count moved in deep sleep");

	// Core variant advances on every core tick that is not paused.
	a_core_rate: assert property (@(posedge ref_clk) disable iff (srst)
		~const_rate_mode & core_tick & deep_sleep_pin_n & ~stamp_wr
		|=> count_ff == $past(count_ff) + 64'h1)
		else $error("core tick missed");

	// Constant variant ignores the core tick.
	a_const_rate: assert property (@(posedge ref_clk) disable iff (srst)
		const_rate_mode & core_tick & ~const_tick & ~stamp_wr & ~rd_req
		|=> count_ff == $past(count_ff))
		else $error("constant rate count followed core clock");

	// Successive allowed read samples with no write or wrap between them strictly increase.
	a_read_grows: assert property (@(posedge ref_clk) disable iff (srst)
		rd_take & seen_ff & ~wrote_ff & (last_rd_ff != {CSC_CNT_W{1'b1}})
		|-> count_ff > last_rd_ff)
		else $error("read sample did not increase");

	// An allowed read answers next cycle with the count of its request edge.
	a_read_sample: assert property (@(posedge ref_clk) disable iff (srst)
		rd_take
		|=> rd_ack & ~rd_fault & (rd_data == $past(count_ff)))
		else $error("read sample wrong");

	// Restricted reads outside level zero fault one cycle later.
	a_read_restrict: assert property (@(posedge ref_clk) disable iff (srst)
		rd_req & ctl4_ff[CSC_RESTRICT_BIT] & ((rd_cpl != CSC_CPL_KERNEL) | rd_v86)
		|=> rd_ack & rd_fault)
		else $error("restricted read not refused");

	// A refused read leaves the last sample in place.
	a_read_refused: assert property (@(posedge ref_clk) disable iff (srst)
		rd_req & ~allow
		|=> rd_ack & rd_fault & $stable(rd_data))
		else $error("refused read changed the sample");

	// With the flag clear every level may read.
	a_read_open: assert property (@(posedge ref_clk) disable iff (srst)
		rd_req & ~ctl4_ff[CSC_RESTRICT_BIT]
		|=> rd_ack & ~rd_fault)
		else $error("unrestricted read refused");

	// No request, no answer.
	a_read_quiet: assert property (@(posedge ref_clk) disable iff (srst)
		~rd_req
		|=> ~rd_ack & ~rd_fault)
		else $error("read answer without request");

	// Control register four takes the written word.
	a_ctl4_load: assert property (@(posedge ref_clk) disable iff (srst)
		ctl4_wr
		|=> ctl4_q == $past(ctl4_wdata))
		else $error("control register four not loaded");

	// Without a tick, an allowed read or a write the count holds.
	a_count_idle: assert property (@(posedge ref_clk) disable iff (srst)
		~bump & ~stamp_wr
		|=> $stable(count_ff))
		else $error("count moved with no cause");

	// Constant variant advances on every fixed-rate strobe that is not paused.
	a_const_tick: assert property (@(posedge ref_clk) disable iff (srst)
		const_rate_mode & const_tick & (deep_sleep_pin_n | ~sleep_stop_en) & ~stamp_wr
		|=> count_ff == $past(count_ff) + 64'h1)
		else $error("constant rate strobe missed");

	// Register read returns the full count sampled at the request.
	a_msr_read: assert property (@(posedge ref_clk) disable iff (srst)
		msr_rd & (msr_addr == CSC_STAMP_ADDR)
		|=> msr_ack & ~msr_fault & (msr_rdata == $past(count_ff)))
		else $error("model register read mismatch");

	// Accesses to any other address are refused.
	a_msr_fault: assert property (@(posedge ref_clk) disable iff (srst)
		(msr_rd | msr_wr) & (msr_addr != CSC_STAMP_ADDR)
		|=> msr_ack & msr_fault)
		else $error("unmapped access not refused");

	// No access, no answer.
	a_msr_quiet: assert property (@(posedge ref_clk) disable iff (srst)
		~msr_rd & ~msr_wr
		|=> ~msr_ack & ~msr_fault)
		else $error("register answer without access");

	// Narrow write loads the low half and clears the high half, beating a tick.
	a_msr_narrow: assert property (@(posedge ref_clk) disable iff (srst)
		stamp_wr & ~full_width_write
		|=> count_ff == {{CSC_HALF_W{1'b0}}, $past(msr_wdata[CSC_HALF_W-1:0])})
		else $error("narrow write wrong");

	// Full write loads all bits, then counting resumes from there.
	a_msr_full: assert property (@(posedge ref_clk) disable iff (srst)
		stamp_wr & full_width_write
		|=> count_ff == $past(msr_wdata))
		else $error("full write wrong");

	// Feature leaf reports the counter as present.
	a_id_present: assert property (@(posedge ref_clk) disable iff (srst)
		id_req & (id_leaf == CSC_ID_FEATURE_LEAF) |=> id_ack & id_edx[CSC_PRESENT_BIT])
		else $error("counter present bit missing");

	// Other leaves report nothing.
	a_id_other: assert property (@(posedge ref_clk) disable iff (srst)
		id_req & (id_leaf != CSC_ID_FEATURE_LEAF) |=> id_ack & (id_edx == 32'h0))
		else $error("other leaf not zero");
endmodule // csc_counter
`default_nettype wire

// [rtl/csc_pkg.sv]
// Shared constants for the cycle stamp counter block.
`default_nettype none
package csc_pkg;
	// Count width; at 125 MHz a 64-bit count takes thousands of years to wrap.
	localparam int unsigned CSC_CNT_W          = 64;
	localparam int unsigned CSC_HALF_W         = 32;
	localparam int unsigned CSC_ADDR_W         = 32;
	localparam int unsigned CSC_CPL_W          = 2;
	localparam int unsigned CSC_CTL4_W         = 32;
	// Model register address of the count.
	localparam logic [31:0] CSC_STAMP_ADDR     = 32'h0000_0010;
	// Reset values.
	localparam logic [63:0] CSC_STAMP_RESET    = 64'h0;
	localparam logic [31:0] CSC_CTL4_RESET     = 32'h0;
	// Read restriction flag position in control register four.
	localparam int unsigned CSC_RESTRICT_BIT   = 2;
	// Identification query leaf and feature bit that reports the counter.
	localparam logic [31:0] CSC_ID_FEATURE_LEAF = 32'h0000_0001;
	localparam int unsigned CSC_PRESENT_BIT    = 4;
	localparam logic [31:0] CSC_ID_FEATURES    = 32'h0000_0010;
	// Privilege level that is always allowed to read outside virtual-8086 mode.
	localparam logic [1:0]  CSC_CPL_KERNEL     = 2'h0;
	// Clock rate and the least wrap time in years.
	localparam int unsigned CSC_CLK_MHZ        = 125;
	localparam int unsigned CSC_WRAP_YEARS     = 10;
endpackage : csc_pkg
`default_nettype wire

// [rtl/csc_tick_sel.sv]
// Selects the increment source and applies the deep sleep pause.
`default_nettype none
module csc_tick_sel (
	input  wire logic core_tick,
	input  wire logic const_tick,
	input  wire logic const_rate_mode,
	input  wire logic deep_sleep_pin_n,
	input  wire logic sleep_stop_en,
	output logic      tick
);
	import csc_pkg::*;

	logic src_tick;
	logic paused;

	// Core mode follows every internal core cycle; constant mode follows the fixed-rate strobe.
	assign src_tick = const_rate_mode ? const_tick : core_tick;
	// Halt and stop clock do not appear here, so they never pause the count.
	assign paused   = sleep_stop_en & ~deep_sleep_pin_n;
	assign tick     = src_tick & ~paused;
endmodule // csc_tick_sel
`default_nettype wire

// [rtl/csc_read_guard.sv]
// Decides whether a counter read instruction may complete.
`default_nettype none
module csc_read_guard (
	input  wire logic                         restrict_flag,
	input  wire logic [csc_pkg::CSC_CPL_W-1:0] cpl,
	input  wire logic                         v86_mode,
	output logic                              allow
);
	import csc_pkg::*;

	// Virtual-8086 code runs outside level 0, so it is refused once restricted.
	assign allow = ~restrict_flag | ((cpl == CSC_CPL_KERNEL) & ~v86_mode);
endmodule // csc_read_guard
`default_nettype wire

// [bench/csc_counter_tb_top.sv]
// Self-checking testbench for the cycle stamp counter with a cycle-level reference model.
`default_nettype none
module csc_counter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csc_pkg::*;

	localparam int LIMIT = 20000;
	logic        ref_clk, srst, core_tick, const_tick, const_rate_mode, full_width_write;
	logic        halt_instruction_active, stop_clock_pin_n, deep_sleep_pin_n, sleep_stop_en;
	logic        rd_req, rd_v86, rd_ack, rd_fault, ctl4_wr, msr_rd, msr_wr, msr_ack, msr_fault;
	logic        id_req, id_ack, rd_on, mr_on, wr_on, ok, hit, tk;
	logic [1:0]  rd_cpl;
	logic [31:0] ctl4_wdata, ctl4_q, msr_addr, id_leaf, id_edx, m_ctl4, e_edx;
	logic [63:0] rd_data, msr_wdata, msr_rdata, m_cnt, e_rdata, e_mrdata;
	logic        e_rack, e_rflt, e_mack, e_mflt, e_iack;
	int          seed, error_cnt, total_checks, cyc_cnt;

	csc_counter i_csc_counter (.ref_clk(ref_clk), .srst(srst), .core_tick(core_tick),
		.const_tick(const_tick), .const_rate_mode(const_rate_mode),
		.full_width_write(full_width_write), .halt_instruction_active(halt_instruction_active),
		.stop_clock_pin_n(stop_clock_pin_n), .deep_sleep_pin_n(deep_sleep_pin_n),
		.sleep_stop_en(sleep_stop_en), .rd_req(rd_req), .rd_cpl(rd_cpl), .rd_v86(rd_v86),
		.rd_ack(rd_ack), .rd_fault(rd_fault), .rd_data(rd_data), .ctl4_wr(ctl4_wr),
		.ctl4_wdata(ctl4_wdata), .ctl4_q(ctl4_q), .msr_rd(msr_rd), .msr_wr(msr_wr),
		.msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack(msr_ack), .msr_fault(msr_fault),
		.msr_rdata(msr_rdata), .id_req(id_req), .id_leaf(id_leaf), .id_ack(id_ack),
		.id_edx(id_edx));

	// Free-running 125 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Reference model: works out every expected output one edge ahead of the compare.
	always @(posedge ref_clk) begin
		ok = !m_ctl4[CSC_RESTRICT_BIT] || (rd_cpl == CSC_CPL_KERNEL && !rd_v86);
		hit = (msr_addr == CSC_STAMP_ADDR);
		tk = const_rate_mode ? const_tick : core_tick;
		if (sleep_stop_en && !deep_sleep_pin_n) tk = 1'b0;
		e_rack = rd_req;
		e_rflt = rd_req && !ok;
		if (rd_req && ok) e_rdata = m_cnt;
		e_mack = msr_rd || msr_wr;
		e_mflt = e_mack && !hit;
		if (msr_rd) e_mrdata = hit ? m_cnt : 64'h0;
		e_iack = id_req;
		if (id_req) e_edx = (id_leaf == CSC_ID_FEATURE_LEAF) ? CSC_ID_FEATURES : 32'h0;
		if (msr_wr && hit) m_cnt = full_width_write ? msr_wdata : {32'h0, msr_wdata[31:0]};
		else if (tk || (rd_req && ok)) m_cnt = m_cnt + 64'h1;
		if (ctl4_wr) m_ctl4 = ctl4_wdata;
		if (srst) begin
			{m_cnt, e_rdata, e_mrdata} = '0;
			{m_ctl4, e_edx} = '0;
			{e_rack, e_rflt, e_mack, e_mflt, e_iack} = '0;
		end
	end

	// Compares every output mid-cycle, once the edge's updates have settled.
	always @(negedge ref_clk) begin
		if (cyc_cnt != 0) begin
			check(rd_ack, e_rack);
			check(rd_fault, e_rflt);
			check(rd_data, e_rdata);
			check(msr_ack, e_mack);
			check(msr_fault, e_mflt);
			check(msr_rdata, e_mrdata);
			check(id_ack, e_iack);
			check(id_edx, e_edx);
			check(ctl4_q, m_ctl4);
		end
	end

	// Cycle counter that cuts a hang short.
	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == LIMIT) begin
			error_cnt++;
			print_verdict();
		end
	end

	// Compares one value and counts the result.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Drives random traffic for n cycles, just after each rising edge.
	task automatic step(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			core_tick = $random(seed);
			const_tick = ($random(seed) % 4) == 0;
			halt_instruction_active = $random(seed);
			stop_clock_pin_n = $random(seed);
			deep_sleep_pin_n = $random(seed);
			rd_req = rd_on && $random(seed);
			rd_cpl = $random(seed);
			rd_v86 = ($random(seed) % 4) == 0;
			ctl4_wr = ($random(seed) % 8) == 0;
			ctl4_wdata = $random(seed);
			msr_rd = mr_on && $random(seed);
			msr_wr = wr_on && !msr_rd && (($random(seed) % 4) == 0);
			msr_addr = $random(seed) % 2 ? CSC_STAMP_ADDR : $random(seed);
			msr_wdata = {$random(seed), $random(seed)};
			full_width_write = $random(seed);
			id_req = $random(seed);
			id_leaf = $random(seed) % 2 ? CSC_ID_FEATURE_LEAF : 32'($random(seed) % 4);
		end
	endtask

	// One full-width write of the count through the model register.
	task automatic wide_write(input logic [63:0] d);
		@(posedge ref_clk);
		#1;
		{msr_wr, msr_rd, full_width_write} = 3'b101;
		msr_addr = CSC_STAMP_ADDR;
		msr_wdata = d;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence: reset, six traffic mixes, a mid-run reset and a final mix.
	initial begin
		seed = 84;
		{error_cnt, total_checks, cyc_cnt} = '0;
		{srst, stop_clock_pin_n, deep_sleep_pin_n} = 3'b111;
		{core_tick, const_tick, const_rate_mode, full_width_write, halt_instruction_active} = '0;
		{sleep_stop_en, rd_req, rd_cpl, rd_v86, ctl4_wr, ctl4_wdata} = '0;
		{msr_rd, msr_wr, msr_addr, msr_wdata, id_req, id_leaf, rd_on, mr_on, wr_on} = '0;
		{m_cnt, m_ctl4} = '0;
		repeat (16) @(posedge ref_clk);
		#1 srst = 1'b0;
		for (int t = 0; t < 6; t++) begin
			const_rate_mode = t[0];
			sleep_stop_en = t[1];
			rd_on = 1'b1;
			mr_on = (t >= 3);
			wr_on = (t == 4);
			if (t == 5) wide_write(64'hffff_ffff_ffff_fff0);
			step(400);
			$display("test %0d done", t);
		end
		@(posedge ref_clk);
		#1;
		{srst, rd_req, msr_rd, msr_wr, ctl4_wr, id_req} = 6'b100000;
		repeat (3) @(posedge ref_clk);
		#1 srst = 1'b0;
		step(200);
		$display("test 6 done");
		print_verdict();
	end
endmodule // csc_counter_tb_top
`default_nettype wire
